// ==== hw/rcsc_pkg.sv ====
// Purpose: constants and types for the regulator and clock source control block
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes: Behaviour list below
//
// Behaviour
// - control word bits 15:2 reserved, read zero
// - bit 1 selects core level 1.3/1.05 V
// - bit 0 enables usb regulator, else hi-z
// - power-down kills all; else strap and enable
// - clock reference chosen by clock-select strap
// - strap high bypasses generator, external clock direct
// - rtc oscillator off blocks rtc registers
// - reset switches every peripheral clock off
// - gate, soft-reset counter, reset control registers
// - usb oscillator runs with both disables clear
// - reset defaults core level to 1.3 V
// - reset defaults usb regulator disabled
// - regulators return only on wakeup events
package rcsc_pkg;
	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [15:0] regulator_control_off = 16'h7004;
	localparam logic [15:0] peripheral_clock_gate_1_off = 16'h7010;
	localparam logic [15:0] peripheral_clock_gate_2_off = 16'h7014;
	localparam logic [15:0] peripheral_soft_reset_counter_off = 16'h7018;
	localparam logic [15:0] peripheral_reset_control_off = 16'h701C;
	localparam logic [15:0] usb_system_control_off = 16'h7020;
	localparam logic [15:0] rtc_power_management_off = 16'h7024;
	localparam logic [15:0] status_off = 16'h7028;
	// ****************************************************************
	// fields and reset values
	// ****************************************************************
	localparam int core_voltage_bit = 1;
	localparam int usb_enable_bit = 0;
	localparam int usb_osc_disable_bit = 0;
	localparam int usb_osc_bias_disable_bit = 1;
	localparam int bandgap_pd_bit = 0;
	localparam int regulators_pd_bit = 1;
	localparam logic [1:0] regulator_control_rst = 2'h0;
	localparam logic [15:0] clock_gate_rst = 16'hFFFF;
	localparam logic [1:0] usb_system_control_rst = 2'h3;
	localparam logic [1:0] axi_okay = 2'h0;
	localparam logic [1:0] axi_slverr = 2'h2;

	typedef struct packed {
		logic analog_on;
		logic core_on;
		logic usb_on;
		logic core_low_voltage;
	} rcsc_regulator_type;
endpackage

// ==== hw/rcsc_top.sv ====
// Purpose: regulator enables, clock source select, peripheral clock and reset control
// Assumes: all pin inputs synchronous to clk_in; wake inputs already enabled upstream
// Notes: clock gate bits set means clock stopped; reset control bit set holds reset
`timescale 1ns/100ps
module rcsc_top #(
	parameter int periph_count = 16
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [15:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [15:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic core_regulator_strap_in,
	input wire logic clock_select_strap_in,
	input wire logic rtc_oscillator_running_in,
	input wire logic wakeup_in,
	input wire logic rtc_alarm_in,
	input wire logic rtc_supply_cycled_in,
	output logic analog_regulator_on_out,
	output logic core_regulator_on_out,
	output logic core_regulator_low_voltage_out,
	output logic usb_regulator_output_out,
	output logic usb_regulator_output_oen_out,
	output logic reference_from_rtc_out,
	output logic generator_bypass_out,
	output logic usb_oscillator_run_out,
	output logic [2*periph_count-1:0] periph_clock_on_out,
	output logic [periph_count-1:0] periph_reset_out
);
	// ****************************************************************
	// block notes
	// ****************************************************************
	// register bus answers after one registered cycle per channel
	// awready and wready pulse, so back-to-back writes need a gap
	// only byte lanes 0 and 1 reach the 16-bit registers
	// upper byte lanes are ignored on every write
	// unmapped offsets answer slverr and change nothing
	// rtc power management gated by rtc oscillator status
	// power-down bits self-clear one clock after they are set
	// a write in the same cycle as that clear still lands
	// off latch cleared only by wake, alarm or rtc supply cycle
	// wake beats a new power-down request in the same cycle
	// core regulator strap expected static, sampled every cycle
	// clock-select strap captured once, on first edge after reset
	// a later strap change has no effect until the next reset
	// gate bit set stops that clock; reset leaves all stopped
	// reset control bit set holds that peripheral in reset
	// soft reset counter counts down once per clock
	// any nonzero count holds every peripheral reset
	// status word is read only; writes answer okay, no effect
	// regulator outputs lag their inputs by one clock
	// usb pin enable is active low, high while regulator is off
	// usb oscillator runs only with both disable bits clear
	// clock-on outputs: two bits per peripheral reset bit
	// every output port comes from its own flop
	// no long counters: settling waits belong to software

	// ****************************************************************
	// state
	// ****************************************************************
	logic [1:0] regctl_q, regctl_d;
	logic [15:0] gate1_q, gate1_d, gate2_q, gate2_d;
	logic [15:0] src_count_q, src_count_d;
	logic [15:0] peripheral_reset_control_q, peripheral_reset_control_d;
	logic [1:0] usb_system_control_q, usb_system_control_d;
	logic [1:0] rtcpm_q, rtcpm_d;
	logic off_q, off_d;
	logic aw_q, w_q;
	logic [15:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic clk_sel_q;
	logic first_q;
	rcsc_pkg::rcsc_regulator_type reg_q, reg_d;
	logic [2*periph_count-1:0] clk_on_q;
	logic [periph_count-1:0] prst_q;
	// pin-level flops for enable, reference and oscillator outputs
	logic oen_q, ref_q, osc_run_q;

	// ****************************************************************
	// write path decode
	// ****************************************************************
	wire do_write = aw_q & w_q & ~s_axi_bvalid_out;
	wire wr_lo = do_write & wstrb_q[0];
	wire wr_hi = do_write & wstrb_q[1];
	wire hit_reg = awaddr_q == rcsc_pkg::regulator_control_off;
	wire hit_g1 = awaddr_q == rcsc_pkg::peripheral_clock_gate_1_off;
	wire hit_g2 = awaddr_q == rcsc_pkg::peripheral_clock_gate_2_off;
	wire hit_src = awaddr_q == rcsc_pkg::peripheral_soft_reset_counter_off;
	wire hit_prc = awaddr_q == rcsc_pkg::peripheral_reset_control_off;
	wire hit_usb = awaddr_q == rcsc_pkg::usb_system_control_off;
	wire hit_rtc = awaddr_q == rcsc_pkg::rtc_power_management_off;
	wire hit_sta = awaddr_q == rcsc_pkg::status_off;
	wire rtc_ok = rtc_oscillator_running_in;
	wire wr_known = hit_reg | hit_g1 | hit_g2 | hit_src | hit_prc | hit_usb | (hit_rtc & rtc_ok) | hit_sta;
	wire [15:0] wd = {wr_hi ? wdata_q[15:8] : 8'h00, wr_lo ? wdata_q[7:0] : 8'h00};
	wire [15:0] wm = {{8{wr_hi}}, {8{wr_lo}}};
	// writes above bit 1 are dropped, bits read as zero
	assign regctl_d = (wr_lo & hit_reg) ? wd[1:0] : regctl_q;
	assign gate1_d = hit_g1 ? (gate1_q & ~wm) | wd : gate1_q;
	assign gate2_d = hit_g2 ? (gate2_q & ~wm) | wd : gate2_q;
	assign peripheral_reset_control_d = hit_prc ? (peripheral_reset_control_q & ~wm) | wd : peripheral_reset_control_q;
	assign usb_system_control_d = (wr_lo & hit_usb) ? wd[1:0] : usb_system_control_q;
	// a software write wins over the self-clear of the same cycle
	wire rtc_wr = wr_lo & hit_rtc & rtc_ok;
	assign rtcpm_d = rtc_wr ? wd[1:0] : (pd_req ? 2'h0 : rtcpm_q);
	// soft reset counter: loaded value counts down, resets held while nonzero
	assign src_count_d = (hit_src & (wr_lo | wr_hi)) ? (src_count_q & ~wm) | wd :
		(src_count_q != 16'h0000) ? src_count_q - 16'h0001 : src_count_q;

	// ****************************************************************
	// power-down latch and regulator decode
	// ****************************************************************
	wire pd_req = rtcpm_q[rcsc_pkg::bandgap_pd_bit] | rtcpm_q[rcsc_pkg::regulators_pd_bit];
	wire wake = wakeup_in | rtc_alarm_in | rtc_supply_cycled_in;
	assign off_d = wake ? 1'b0 : (pd_req ? 1'b1 : off_q);
	assign reg_d.analog_on = ~off_d;
	assign reg_d.core_on = ~off_d & ~core_regulator_strap_in;
	assign reg_d.usb_on = ~off_d & regctl_q[rcsc_pkg::usb_enable_bit];
	assign reg_d.core_low_voltage = regctl_q[rcsc_pkg::core_voltage_bit];
	wire [31:0] gate_all = {gate2_q, gate1_q};
	wire soft_rst = src_count_q != 16'h0000;
	// oscillator runs with both disable bits clear
	wire osc_enable = ~usb_system_control_q[rcsc_pkg::usb_osc_disable_bit] & ~usb_system_control_q[rcsc_pkg::usb_osc_bias_disable_bit];

	// ****************************************************************
	// read path
	// ****************************************************************
	wire [15:0] status_word = {10'h000, first_q, off_q, rtc_ok, clk_sel_q, reg_q.core_on, reg_q.analog_on};
	wire [15:0] rd_mux =
		(s_axi_araddr_in == rcsc_pkg::regulator_control_off) ? {14'h0000, regctl_q} :
		(s_axi_araddr_in == rcsc_pkg::peripheral_clock_gate_1_off) ? gate1_q :
		(s_axi_araddr_in == rcsc_pkg::peripheral_clock_gate_2_off) ? gate2_q :
		(s_axi_araddr_in == rcsc_pkg::peripheral_soft_reset_counter_off) ? src_count_q :
		(s_axi_araddr_in == rcsc_pkg::peripheral_reset_control_off) ? peripheral_reset_control_q :
		(s_axi_araddr_in == rcsc_pkg::usb_system_control_off) ? {14'h0000, usb_system_control_q} :
		(s_axi_araddr_in == rcsc_pkg::rtc_power_management_off) ? {14'h0000, rtcpm_q} :
		status_word;
	wire rd_known = (s_axi_araddr_in == rcsc_pkg::regulator_control_off) |
		(s_axi_araddr_in == rcsc_pkg::peripheral_clock_gate_1_off) |
		(s_axi_araddr_in == rcsc_pkg::peripheral_clock_gate_2_off) |
		(s_axi_araddr_in == rcsc_pkg::peripheral_soft_reset_counter_off) |
		(s_axi_araddr_in == rcsc_pkg::peripheral_reset_control_off) |
		(s_axi_araddr_in == rcsc_pkg::usb_system_control_off) |
		((s_axi_araddr_in == rcsc_pkg::rtc_power_management_off) & rtc_ok) |
		(s_axi_araddr_in == rcsc_pkg::status_off);
	wire rd_take = s_axi_arvalid_in & s_axi_arready_out;

	// ****************************************************************
	// write channel handshakes
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 16'h0000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= rcsc_pkg::axi_okay;
		end else begin
			s_axi_awready_out <= ~aw_q & ~s_axi_awready_out & ~s_axi_bvalid_out;
			s_axi_wready_out <= ~w_q & ~s_axi_wready_out & ~s_axi_bvalid_out;
			if (s_axi_awvalid_in & s_axi_awready_out) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in & s_axi_wready_out) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata_in;
				wstrb_q <= s_axi_wstrb_in;
			end
			if (do_write) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= wr_known ? rcsc_pkg::axi_okay : rcsc_pkg::axi_slverr;
				aw_q <= 1'b0;
				w_q <= 1'b0;
			end else if (s_axi_bvalid_out & s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// read channel, one-cycle answer
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= rcsc_pkg::axi_okay;
		end else begin
			s_axi_arready_out <= ~s_axi_rvalid_out & ~s_axi_arready_out & ~rd_take;
			if (rd_take) begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= rd_known ? {16'h0000, rd_mux} : 32'h0000_0000;
				s_axi_rresp_out <= rd_known ? rcsc_pkg::axi_okay : rcsc_pkg::axi_slverr;
			end else if (s_axi_rvalid_out & s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end

	// control registers
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			regctl_q <= rcsc_pkg::regulator_control_rst;
			gate1_q <= rcsc_pkg::clock_gate_rst;
			gate2_q <= rcsc_pkg::clock_gate_rst;
			src_count_q <= 16'h0000;
			peripheral_reset_control_q <= 16'h0000;
			usb_system_control_q <= rcsc_pkg::usb_system_control_rst;
			rtcpm_q <= 2'h0;
			off_q <= 1'b0;
		end else begin
			regctl_q <= regctl_d;
			gate1_q <= gate1_d;
			gate2_q <= gate2_d;
			src_count_q <= src_count_d;
			peripheral_reset_control_q <= peripheral_reset_control_d;
			usb_system_control_q <= usb_system_control_d;
			// power-down request self-clears once latched
			rtcpm_q <= rtcpm_d;
			off_q <= off_d;
		end
	end

	// strap capture after release, registered outputs
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			first_q <= 1'b1;
			clk_sel_q <= 1'b0;
			reg_q <= '0;
			clk_on_q <= '0;
			prst_q <= '0;
		end else begin
			first_q <= 1'b0;
			if (first_q) begin
				clk_sel_q <= clock_select_strap_in;
			end
			reg_q <= reg_d;
			clk_on_q <= ~gate_all[2*periph_count-1:0];
			prst_q <= peripheral_reset_control_q[periph_count-1:0] | {periph_count{soft_rst}};
		end
	end

	// ****************************************************************
	// pin-level output flops
	// ****************************************************************
	// pin enable tracks the regulator flop, reference captures the strap once after reset
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			oen_q <= 1'b1;
			ref_q <= 1'b1;
			osc_run_q <= 1'b0;
		end else begin
			oen_q <= ~reg_d.usb_on;
			if (first_q) begin
				ref_q <= ~clock_select_strap_in;
			end
			osc_run_q <= osc_enable;
		end
	end

	// ****************************************************************
	// output drive
	// ****************************************************************
	assign analog_regulator_on_out = reg_q.analog_on;
	assign core_regulator_on_out = reg_q.core_on;
	assign core_regulator_low_voltage_out = reg_q.core_low_voltage;
	assign usb_regulator_output_out = reg_q.usb_on;
	assign usb_regulator_output_oen_out = oen_q;
	assign reference_from_rtc_out = ref_q;
	assign generator_bypass_out = clk_sel_q;
	assign usb_oscillator_run_out = osc_run_q;
	assign periph_clock_on_out = clk_on_q;
	assign periph_reset_out = prst_q;
endmodule

// ==== verification/rcsc_top_sva.sv ====
// Purpose: port assertions for rcsc_top
// Assumes: one clock, sync active-low reset
// Notes: bound from the bench file
`timescale 1ns/100ps
module rcsc_top_sva #(
	parameter int periph_count = 16
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic core_regulator_strap_in,
	input wire logic wakeup_in,
	input wire logic analog_regulator_on_out,
	input wire logic core_regulator_on_out,
	input wire logic usb_regulator_output_out,
	input wire logic usb_regulator_output_oen_out,
	input wire logic generator_bypass_out,
	input wire logic [2*periph_count-1:0] periph_clock_on_out
);
	// ********
	// checks
	// ********
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// address and data taken at one edge
	sequence both_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	write_resp_a: assert property (both_taken |-> ##2 s_axi_bvalid_out)
		else $error("write response late");
	bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped");
	read_resp_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read data late");
	rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> $stable(s_axi_rdata_out))
		else $error("read data changed");
	strap_off_a: assert property (core_regulator_strap_in |=> !core_regulator_on_out)
		else $error("core on with strap high");
	pd_all_off_a: assert property (!analog_regulator_on_out |-> !core_regulator_on_out)
		else $error("core on during power-down");
	usb_pin_a: assert property (usb_regulator_output_oen_out == !usb_regulator_output_out)
		else $error("usb output enable wrong");
	bypass_once_a: assert property ($past(rstn_in, 3) |-> $stable(generator_bypass_out))
		else $error("clock select moved");
	clk_reset_a: assert property (!$past(rstn_in) |-> periph_clock_on_out == '0)
		else $error("clock on after reset");
	wake_on_a: assert property (wakeup_in |-> ##[1:2] analog_regulator_on_out)
		else $error("no wake");
endmodule

// ==== verification/rcsc_top_bench.sv ====
// Purpose: self-checking bench for rcsc_top
// Assumes: 40 MHz clock, AXI4-Lite master tasks
// Notes: clock-select strap high through first reset
// Notes: generator programming and timer settling stay with firmware
`timescale 1ns/100ps
module rcsc_top_bench;
	localparam int periph_count = 16;
	localparam logic [1:0] ok = rcsc_pkg::axi_okay;
	localparam logic [1:0] bad = rcsc_pkg::axi_slverr;
	int errors = 0;
	int checks = 0;
	logic clk_in, rstn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
	logic core_regulator_strap_in, clock_select_strap_in, rtc_oscillator_running_in;
	logic wakeup_in, rtc_alarm_in, rtc_supply_cycled_in;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic analog_regulator_on_out, core_regulator_on_out, core_regulator_low_voltage_out;
	logic usb_regulator_output_out, usb_regulator_output_oen_out;
	logic reference_from_rtc_out, generator_bypass_out, usb_oscillator_run_out;
	logic [15:0] s_axi_awaddr_in, s_axi_araddr_in, periph_reset_out;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, periph_clock_on_out;
	logic [3:0] s_axi_wstrb_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	rcsc_top #(.periph_count(periph_count)) rcsc_top_inst (.*);
	// ********
	// bus tasks
	// ********
	initial begin
		clk_in = 1'h0;
		forever #12.5 clk_in = ~clk_in;
	end
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// write with both channels offered together
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'h1;
		s_axi_wvalid_in <= 1'h1;
		s_axi_bready_in <= 1'h1;
		do begin
			@(posedge clk_in);
			n++;
			if (s_axi_awready_out && s_axi_awvalid_in)
				s_axi_awvalid_in <= 1'h0;
			if (s_axi_wready_out && s_axi_wvalid_in)
				s_axi_wvalid_in <= 1'h0;
		end while (!s_axi_bvalid_out && n < 40);
		s_axi_bready_in <= 1'h0;
		if (n >= 40) begin
			errors++;
			end_of_test();
		end
		chk(s_axi_bresp_out, er);
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'h1;
		s_axi_rready_in <= 1'h1;
		do begin
			@(posedge clk_in);
			n++;
			if (s_axi_arready_out && s_axi_arvalid_in)
				s_axi_arvalid_in <= 1'h0;
		end while (!s_axi_rvalid_out && n < 40);
		s_axi_rready_in <= 1'h0;
		if (n >= 40) begin
			errors++;
			end_of_test();
		end
		chk(s_axi_rdata_out, ed);
		chk(s_axi_rresp_out, er);
		@(posedge clk_in);
	endtask
	// ********
	// scenarios
	// ********
	task automatic t_ctrl;
		rd(16'h7004, 32'h0000_0000, ok);
		chk({core_regulator_low_voltage_out, usb_regulator_output_oen_out}, 2'h1);
		chk({generator_bypass_out, reference_from_rtc_out, usb_oscillator_run_out}, 3'h4);
		wr(16'h7004, 32'hFFFF_FFFF, ok);
		rd(16'h7004, 32'h0000_0003, ok);
		chk({core_regulator_low_voltage_out, usb_regulator_output_out}, 2'h3);
		core_regulator_strap_in <= 1'h1;
		repeat (2) @(posedge clk_in);
		chk({analog_regulator_on_out, core_regulator_on_out}, 2'h2);
		core_regulator_strap_in <= 1'h0;
		for (int i = 0; i < 2; i++) begin
			wr(16'h7024, 32'h0000_0001 << i, ok);
			repeat (2) @(posedge clk_in);
			chk({analog_regulator_on_out, core_regulator_on_out, usb_regulator_output_out}, 3'h0);
			wakeup_in <= (i == 0);
			rtc_alarm_in <= (i == 1);
			@(posedge clk_in);
			{wakeup_in, rtc_alarm_in} <= 2'h0;
			repeat (2) @(posedge clk_in);
			chk({analog_regulator_on_out, core_regulator_on_out, usb_regulator_output_out}, 3'h7);
		end
		$display("regulator test done");
	endtask
	task automatic t_misc;
		for (int v = 0; v < 4; v++) begin
			wr(16'h7020, 32'(v), ok);
			chk(usb_oscillator_run_out, v == 0);
		end
		rtc_oscillator_running_in <= 1'h0;
		wr(16'h7024, 32'h0000_0002, bad);
		chk(analog_regulator_on_out, 1'h1);
		rd(16'h7030, 32'h0000_0000, bad);
		rtc_oscillator_running_in <= 1'h1;
		wr(16'h7010, 32'h0000_FFFE, ok);
		wr(16'h7014, 32'h0000_7FFF, ok);
		chk(periph_clock_on_out, 32'h8000_0001);
		wr(16'h7010, 32'h0000_FFFF, ok);
		wr(16'h7014, 32'h0000_FFFF, ok);
		chk(periph_clock_on_out, 32'h0000_0000);
		wr(16'h701C, 32'h0000_8001, ok);
		chk(periph_reset_out, 16'h8001);
		wr(16'h701C, 32'h0000_0000, ok);
		wr(16'h7018, 32'h0000_0004, ok);
		chk(periph_reset_out, 16'hFFFF);
		repeat (8) @(posedge clk_in);
		chk(periph_reset_out, 16'h0000);
		clock_select_strap_in <= 1'h0;
		rstn_in <= 1'h0;
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'h1;
		repeat (3) @(posedge clk_in);
		chk(periph_clock_on_out, 32'h0000_0000);
		clock_select_strap_in <= 1'h1;
		repeat (3) @(posedge clk_in);
		chk({generator_bypass_out, reference_from_rtc_out}, 2'h1);
		$display("clock test done");
	endtask
	initial begin
		{rstn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 6'h00;
		{core_regulator_strap_in, wakeup_in, rtc_alarm_in, rtc_supply_cycled_in} = 4'h0;
		{clock_select_strap_in, rtc_oscillator_running_in} = 2'h3;
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 64'h0000_0000_0000_0000;
		s_axi_wstrb_in = 4'hF;
		repeat (6) @(posedge clk_in);
		rstn_in <= 1'h1;
		@(posedge clk_in);
		t_ctrl();
		t_misc();
		end_of_test();
	end
endmodule
bind rcsc_top rcsc_top_sva #(.periph_count(periph_count)) rcsc_top_sva_inst (.*);
